// File: hw/conv_ctrl_pkg.sv
// constants and types for the converter calibration and reference-detect control
// ==========================================================================
package conv_ctrl_pkg;
   localparam int DATA_W = 24;
   localparam logic [2:0] SEL_STATUS = 3'h0;
   localparam logic [2:0] SEL_CONFIG = 3'h2;
   localparam logic [2:0] SEL_DATA = 3'h3;
   localparam logic [2:0] SEL_OFFSET = 3'h6;
   localparam logic [2:0] SEL_FULL_SCALE = 3'h7;
   localparam logic [23:0] OFFSET_RESET = 24'h800000;
   localparam logic [23:0] FULL_SCALE_DEFAULT = 24'h500000; // arbitrary stand-in for trim
   localparam logic [23:0] ALL_ONES = 24'hFFFFFF;
   // configuration word fields
   localparam int CFG_GAIN_LSB = 0;
   localparam int CFG_BUF_POS = 4;
   localparam int CFG_REFCHK_POS = 6;
   localparam int CFG_PSEUDO_POS = 18;
   localparam int CFG_CH_LSB = 8;
   localparam int CFG_REFERENCE_SOURCE_SELECT_POS = 20;
   localparam int CFG_LOWPAIR_POS = 21;
   localparam int CFG_EXTCLK_POS = 22;
   localparam int CFG_CLKOUT_POS = 23;
   localparam logic [23:0] CONFIG_RESET = 24'h000117;
   // status word fields
   localparam int ST_MISSING_REFERENCE_FLAG_POS = 3;
   localparam int ST_ERR_POS = 6;
   localparam int ST_WRBLK_POS = 5;
   // reference thresholds in millivolts (8-bit code = 10 mV per step)
   localparam int REF_LOW_MV = 300;
   localparam int REF_HIGH_MV = 600;
   localparam int REF_MV_PER_STEP = 10;
   localparam logic [7:0] REF_LOW_CODE = 8'(REF_LOW_MV / REF_MV_PER_STEP);
   localparam logic [7:0] REF_HIGH_CODE = 8'(REF_HIGH_MV / REF_MV_PER_STEP);
   // internal modulator clock, kHz
   localparam int INT_CLK_KHZ = 4920;
   typedef enum logic [1:0] {OP_IDLE, OP_CONVERT, OP_ZERO_CAL, OP_FULL_CAL} op_e;
endpackage : conv_ctrl_pkg

// File: hw/ref_detect.sv
// reference-presence detector with hysteresis
`timescale 1ns/1ns
`default_nettype none
module ref_detect
   import conv_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic check_en,
   input wire logic [7:0] ref_level,
   output logic missing_reference_flag
);
   // ==========================================================================
   // comparator with band; inside band the flag keeps its value
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         missing_reference_flag <= 1'b0;
      end else if (!check_en) begin
         missing_reference_flag <= 1'b0;
      end else if (ref_level < REF_LOW_CODE) begin
         missing_reference_flag <= 1'b1;
      end else if (ref_level > REF_HIGH_CODE) begin
         missing_reference_flag <= 1'b0;
      end else begin
         missing_reference_flag <= missing_reference_flag;
      end
   end
endmodule : ref_detect
`default_nettype wire

// File: hw/conv_ctrl.sv
// register file, calibration and analog routing control of the converter
`timescale 1ns/1ns
`default_nettype none
module conv_ctrl
   import conv_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [2:0] register_select_code,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [23:0] wr_data,
   output logic [23:0] rd_data_q,
   input wire logic [1:0] op_cmd,
   input wire logic op_start,
   input wire logic op_done,
   input wire logic [23:0] op_result,
   input wire logic [7:0] ref_level,
   input wire logic ext_clk_present,
   output logic busy_q,
   output logic [23:0] result_q,
   output logic result_valid_q,
   output logic [2:0] gain_sel_q,
   output logic [3:0] pos_input_q,
   output logic [4:0] neg_input_q,
   output logic buffer_en_q,
   output logic second_ref_sel_q,
   output logic shared_pins_as_ref_q,
   output logic ext_clk_sel_q,
   output logic clk_out_en_q,
   output logic missing_reference_flag_q,
   output logic error_q,
   output logic write_blocked_q
);
   // ==========================================================================
   // state
   logic [23:0] offset_q;
   logic [23:0] full_scale_q;
   logic [23:0] config_q;
   op_e op_q;
   logic missing_reference_flag_seen_q;
   logic missing_reference_flag_raw;
   logic coef_wr;
   logic cfg_busy_wr;

   assign coef_wr = wr_en && (register_select_code == SEL_OFFSET
                               || register_select_code == SEL_FULL_SCALE);
   assign cfg_busy_wr = wr_en && register_select_code == SEL_CONFIG;

   ref_detect u_ref_detect (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .check_en(config_q[CFG_REFCHK_POS]),
      .ref_level(ref_level),
      .missing_reference_flag(missing_reference_flag_raw)
   );

   // ==========================================================================
   // operation sequencer; one operation runs at a time
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         op_q <= OP_IDLE;
      end else begin
         case (op_q)
            OP_IDLE: begin
               if (op_start) begin
                  op_q <= op_e'(op_cmd);
               end
            end
            OP_CONVERT, OP_ZERO_CAL, OP_FULL_CAL: begin
               if (op_done) begin
                  op_q <= OP_IDLE;
               end
            end
            default: op_q <= OP_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (op_q == OP_IDLE) ? (op_start && op_cmd != 2'h0) : !op_done;
      end
   end

   // ==========================================================================
   // any missing-reference sighting during a calibration spoils it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         missing_reference_flag_seen_q <= 1'b0;
      end else if (op_q == OP_IDLE) begin
         missing_reference_flag_seen_q <= 1'b0;
      end else if (missing_reference_flag_raw) begin
         missing_reference_flag_seen_q <= 1'b1;
      end
   end

   // ==========================================================================
   // offset coefficient; host must idle first, busy writes dropped
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         offset_q <= OFFSET_RESET;
      end else if (op_q == OP_ZERO_CAL && op_done) begin
         if (!(missing_reference_flag_seen_q || missing_reference_flag_raw)) begin
            offset_q <= op_result;
         end
      end else if (wr_en && register_select_code == SEL_OFFSET && op_q == OP_IDLE) begin
         offset_q <= wr_data;
      end
   end

   // full-scale coefficient; reset loads the factory value
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         full_scale_q <= FULL_SCALE_DEFAULT;
      end else if (op_q == OP_FULL_CAL && op_done) begin
         if (!(missing_reference_flag_seen_q || missing_reference_flag_raw)) begin
            full_scale_q <= op_result;
         end
      end else if (wr_en && register_select_code == SEL_FULL_SCALE && op_q == OP_IDLE) begin
         full_scale_q <= wr_data;
      end
   end

   // configuration register: written at once, even mid-conversion; only the routing outputs wait for idle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         config_q <= CONFIG_RESET;
      end else if (cfg_busy_wr) begin
         config_q <= wr_data;
      end
   end

   // ==========================================================================
   // error flag sticky until the next operation start; write-block flag sticky until a status read
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         error_q <= 1'b0;
      end else if ((op_q == OP_ZERO_CAL || op_q == OP_FULL_CAL) && op_done
                   && (missing_reference_flag_seen_q || missing_reference_flag_raw)) begin
         error_q <= 1'b1;
      end else if (op_q == OP_IDLE && op_start) begin
         error_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         write_blocked_q <= 1'b0;
      end else if (coef_wr && op_q != OP_IDLE) begin
         write_blocked_q <= 1'b1;
      end else if (rd_en && register_select_code == SEL_STATUS) begin
         write_blocked_q <= 1'b0; // reading status clears it
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         missing_reference_flag_q <= 1'b0;
      end else begin
         missing_reference_flag_q <= missing_reference_flag_raw;
      end
   end

   // ==========================================================================
   // conversion result; all ones while reference is missing
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         result_q <= 24'h000000;
         result_valid_q <= 1'b0;
      end else if (op_q == OP_CONVERT && op_done) begin
         result_q <= missing_reference_flag_raw ? ALL_ONES : op_result;
         result_valid_q <= 1'b1;
      end else begin
         result_valid_q <= 1'b0;
      end
   end

   // ==========================================================================
   // analog routing: only updated while idle, never mid-conversion
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         gain_sel_q <= 3'h7;
         pos_input_q <= 4'h0;
         neg_input_q <= 5'h01;
         buffer_en_q <= 1'b1;
         second_ref_sel_q <= 1'b0;
         shared_pins_as_ref_q <= 1'b0;
      end else if (op_q == OP_IDLE) begin
         gain_sel_q <= config_q[CFG_GAIN_LSB +: 3];
         pos_input_q <= config_q[CFG_CH_LSB + 4 +: 4];
         // pseudo mode ties the negative side to the common pin (code 16)
         neg_input_q <= config_q[CFG_PSEUDO_POS] ? 5'h10
                        : {1'b0, config_q[CFG_CH_LSB +: 4]};
         buffer_en_q <= config_q[CFG_BUF_POS];
         second_ref_sel_q <= config_q[CFG_REFERENCE_SOURCE_SELECT_POS];
         shared_pins_as_ref_q <= !config_q[CFG_LOWPAIR_POS]
                                 && config_q[CFG_REFERENCE_SOURCE_SELECT_POS];
      end
   end

   // clock source: external only if one is actually present
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ext_clk_sel_q <= 1'b0;
         clk_out_en_q <= 1'b0;
      end else begin
         ext_clk_sel_q <= config_q[CFG_EXTCLK_POS] && ext_clk_present;
         clk_out_en_q <= config_q[CFG_CLKOUT_POS] && !config_q[CFG_EXTCLK_POS];
      end
   end

   // ==========================================================================
   // read port, registered; unmapped codes return zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rd_data_q <= 24'h000000;
      end else if (rd_en) begin
         case (register_select_code)
            SEL_STATUS: rd_data_q <= {16'h0000, 1'b0, error_q, write_blocked_q, 1'b0,
                                missing_reference_flag_q, 3'h0};
            SEL_CONFIG: rd_data_q <= config_q;
            SEL_DATA: rd_data_q <= result_q;
            SEL_OFFSET: rd_data_q <= offset_q;
            SEL_FULL_SCALE: rd_data_q <= full_scale_q;
            default: rd_data_q <= 24'h000000;
         endcase
      end
   end
endmodule : conv_ctrl
`default_nettype wire

// File: verification/conv_ctrl_props.sv
// port-level property checker for the converter control block
`timescale 1ns/1ns
`default_nettype none
module conv_ctrl_props
   import conv_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [2:0] register_select_code,
   input wire logic wr_en,
   input wire logic [1:0] op_cmd,
   input wire logic op_start,
   input wire logic op_done,
   input wire logic [7:0] ref_level,
   input wire logic busy_q,
   input wire logic [23:0] result_q,
   input wire logic result_valid_q,
   input wire logic [2:0] gain_sel_q,
   input wire logic [4:0] neg_input_q,
   input wire logic missing_reference_flag_q,
   input wire logic error_q,
   input wire logic write_blocked_q
);
   // ====
   // helper: running operation is a calibration
   logic cal_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge core_clk) begin
      if (!rst_n) cal_q <= 1'b0;
      else if (op_start && !busy_q) cal_q <= op_cmd[1];
   end
   // ====
   // operation sequencing
   chk_start_busy: assert property (op_start && !busy_q && op_cmd != 2'h0 |=> busy_q)
      else $error("busy did not rise");
   chk_done_idle: assert property (busy_q && op_done |=> !busy_q)
      else $error("busy did not fall");
   chk_valid_pulse: assert property (result_valid_q |=> !result_valid_q)
      else $error("valid wider than one cycle");
   chk_missing_reference_flag_ones: assert property (result_valid_q && !cal_q && missing_reference_flag_q
      && $past(missing_reference_flag_q) |-> result_q == ALL_ONES)
      else $error("result not all ones");
   chk_route_hold: assert property (busy_q && $past(busy_q)
      |=> $stable(gain_sel_q) && $stable(neg_input_q))
      else $error("routing moved mid operation");
   chk_neg_range: assert property (neg_input_q <= 5'h10)
      else $error("negative input out of range");
   // ====
   // reference detect and coefficient protection
   chk_flag_clear: assert property ((ref_level > REF_HIGH_CODE)[*4]
      |-> !missing_reference_flag_q)
      else $error("flag kept above high threshold");
   chk_flag_hold: assert property ((ref_level >= REF_LOW_CODE && !wr_en
      && ref_level <= REF_HIGH_CODE)[*4] |-> $stable(missing_reference_flag_q))
      else $error("flag moved inside band");
   chk_write_block: assert property (busy_q && wr_en && register_select_code[2:1] == 2'h3
      |=> write_blocked_q)
      else $error("busy write not reported");
   chk_cal_error: assert property (cal_q && busy_q && op_done && missing_reference_flag_q
      |=> error_q)
      else $error("calibration error not set");
   cover property (result_valid_q && missing_reference_flag_q);
   cover property (cal_q && op_done && missing_reference_flag_q);
   cover property (busy_q && wr_en);
endmodule : conv_ctrl_props
bind conv_ctrl conv_ctrl_props u_props (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .register_select_code(register_select_code),
   .wr_en(wr_en),
   .op_cmd(op_cmd),
   .op_start(op_start),
   .op_done(op_done),
   .ref_level(ref_level),
   .busy_q(busy_q),
   .result_q(result_q),
   .result_valid_q(result_valid_q),
   .gain_sel_q(gain_sel_q),
   .neg_input_q(neg_input_q),
   .missing_reference_flag_q(missing_reference_flag_q),
   .error_q(error_q),
   .write_blocked_q(write_blocked_q)
);
`default_nettype wire

// File: verification/mod_backend_model.sv
// behavioural modulator back end answering started operations
`timescale 1ns/1ns
`default_nettype none
module mod_backend_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic busy_q,
   input wire logic [3:0] lat,
   input wire logic [23:0] res_in,
   output logic op_done,
   output logic [23:0] op_result
);
   // ====
   // one done pulse lat cycles into each operation; result churns otherwise
   logic [3:0] cnt_q;
   logic sent_q;
   always_ff @(posedge core_clk) begin
      op_done <= 1'b0;
      op_result <= rst_n ? ~op_result : 24'h5A5A5A;
      if (!busy_q) begin
         cnt_q <= 4'h0;
         sent_q <= 1'b0;
      end else if (!sent_q && cnt_q == lat) begin
         op_done <= 1'b1;
         op_result <= res_in;
         sent_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule : mod_backend_model
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import conv_ctrl_pkg::*;
   logic core_clk, rst_n, wr_en, rd_en, op_start, op_done, ext_clk_present, busy_q;
   logic [2:0] register_select_code, gain_sel_q;
   logic [1:0] op_cmd;
   logic [23:0] wr_data, rd_data_q, op_result, result_q, res_in, v, q, cfg;
   logic [7:0] ref_level;
   logic [3:0] lat, pos_input_q;
   logic [4:0] neg_input_q;
   logic result_valid_q, buffer_en_q, second_ref_sel_q, shared_pins_as_ref_q, clk_out_en_q;
   logic ext_clk_sel_q, missing_reference_flag_q, error_q, write_blocked_q;
   logic [2:0] gains [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
   int n_errors = 0;
   int samples_checked = 0;
   conv_ctrl u_dut (.*);
   mod_backend_model u_model (.*);
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // ====
   // shared tasks
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task automatic wr(input logic [2:0] sel, input logic [23:0] d);
      @(negedge core_clk);
      register_select_code = sel;
      wr_data = d;
      wr_en = 1'b1;
      @(negedge core_clk);
      wr_en = 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] sel);
      @(negedge core_clk);
      register_select_code = sel;
      rd_en = 1'b1;
      @(negedge core_clk);
      rd_en = 1'b0;
      q = rd_data_q;
   endtask : rd
   task automatic start(input logic [1:0] cmd, input logic [23:0] r, input logic [3:0] l);
      res_in = r;
      lat = l;
      @(negedge core_clk);
      op_cmd = cmd;
      op_start = 1'b1;
      @(negedge core_clk);
      op_start = 1'b0;
   endtask : start
   // bounded wait for the end of an operation
   task automatic finish(input logic [1:0] cmd);
      int i;
      for (i = 0; i < 40 && busy_q === 1'b1; i++) @(negedge core_clk);
      if (i == 40) begin
         n_errors++;
         end_sim();
      end else if (cmd == 2'h1) begin
         check({23'h0, result_valid_q}, 24'h1);
      end
   endtask : finish
   task automatic op(input logic [1:0] cmd, input logic [23:0] r);
      start(cmd, r, 4'($urandom_range(0, 9)));
      finish(cmd);
   endtask : op
   task automatic settle(input logic [7:0] lvl);
      ref_level = lvl;
      repeat (5) @(negedge core_clk);
   endtask : settle
   function automatic logic [23:0] exp_neg(input logic [23:0] c);
      return c[CFG_PSEUDO_POS] ? 24'h10 : {20'h0, c[11:8]};
   endfunction : exp_neg
   // ====
   // main sequence
   initial begin
      void'($urandom(32'h7ffc97e7));
      {rst_n, wr_en, rd_en, op_start, op_cmd, wr_data, register_select_code} = '0;
      {ext_clk_present, ref_level, lat, res_in} = {1'b1, 8'h64, 4'h0, 24'h0};
      repeat (20) @(negedge core_clk);
      rst_n = 1'b1;
      rd(SEL_OFFSET);
      check(q, OFFSET_RESET);
      rd(SEL_FULL_SCALE);
      check(q, FULL_SCALE_DEFAULT);
      // coefficient writes only while the converter is idle
      for (int k = 0; k < 4; k++) begin
         v = 24'($urandom);
         wr(k[0] ? SEL_FULL_SCALE : SEL_OFFSET, v);
         rd(k[0] ? SEL_FULL_SCALE : SEL_OFFSET);
         check(q, v);
      end
      wr(SEL_CONFIG, 24'h000157);
      for (int k = 0; k < 2; k++) begin
         v = 24'($urandom);
         op(2'h2 + 2'(k), v);
         rd(k[0] ? SEL_FULL_SCALE : SEL_OFFSET);
         check(q, v);
      end
      settle(8'h0A);
      check({23'h0, missing_reference_flag_q}, 24'h1);
      op(2'h1, 24'h123456);
      check(result_q, ALL_ONES);
      settle(8'h2D);
      rd(SEL_STATUS);
      check({23'h0, q[ST_MISSING_REFERENCE_FLAG_POS]}, 24'h1);
      rd(SEL_OFFSET);
      v = q;
      op(2'h2, ~v);
      rd(SEL_OFFSET);
      check(q, v);
      check({23'h0, error_q}, 24'h1);
      rd(SEL_STATUS);
      check({23'h0, q[ST_ERR_POS]}, 24'h1);
      settle(8'h46);
      check({23'h0, missing_reference_flag_q}, 24'h0);
      op(2'h1, 24'h00BEEF);
      check({23'h0, error_q}, 24'h0);
      check(result_q, 24'h00BEEF);
      // writes landing inside a long conversion: dropped or deferred
      start(2'h1, 24'h0, 4'hF);
      wr(SEL_OFFSET, ~v);
      @(negedge core_clk);
      check({23'h0, write_blocked_q}, 24'h1);
      wr(SEL_CONFIG, 24'h000140);
      @(negedge core_clk);
      check({21'h0, gain_sel_q}, 24'h000007);
      finish(2'h1);
      rd(SEL_STATUS);
      check({23'h0, q[ST_WRBLK_POS]}, 24'h1);
      check({23'h0, write_blocked_q}, 24'h0);
      rd(SEL_OFFSET);
      check(q, v);
      check({21'h0, gain_sel_q}, 24'h000000);
      wr(SEL_CONFIG, 24'h000117);
      settle(8'h05);
      check({23'h0, missing_reference_flag_q}, 24'h0);
      settle(8'h64);
      foreach (gains[k]) begin
         cfg = (24'($urandom) & 24'hF4FF50) | {21'h0, gains[k]};
         ext_clk_present = 1'($urandom);
         wr(SEL_CONFIG, cfg);
         @(negedge core_clk);
         check({17'h0, gain_sel_q, pos_input_q}, {17'h0, gains[k], cfg[15:12]});
         check({19'h0, neg_input_q}, exp_neg(cfg));
         check({22'h0, buffer_en_q, second_ref_sel_q}, {22'h0, cfg[4], cfg[20]});
         check({23'h0, shared_pins_as_ref_q}, {23'h0, cfg[20] & ~cfg[21]});
         // clock out only when running on the internal clock
         v = {22'h0, cfg[22] & ext_clk_present, cfg[23] & ~cfg[22]};
         check({22'h0, ext_clk_sel_q, clk_out_en_q}, v);
      end
      end_sim();
   end
endmodule : testbench
`default_nettype wire
